// file: address_latch_buffer_tb.sv
// Random-stimulus bench comparing the buffer with a cycle model
module address_latch_buffer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import alb_pkg::*;
  logic       clk = 0, nrst = 0, ale = 0, bz = 0, b20 = 0, kg = 0, pg = 0, am = 0, bq = 0;
  logic       mn = 1, bhe_d = 1, cbhe_d = 1, ior = 1, iow = 1, mrd = 1, mwr = 1;
  logic       bhe_o, bhe_oe, cbhe_o, cbhe_oe, b20_o, sel, cd_oe, pb_oe;
  logic       e_cb, e_b, e_20, e_sel;
  alb_low_t   al = '0;
  alb_high_t  ah = '0;
  alb_data_t  cd = '0, pdat = '0, cd_o, pb_o, pm_bus, e_cd, e_pd;
  alb_latlo_t lo, e_lo;
  alb_lathi_t hi, e_hi;
  alb_upper_t up, e_up;
  int         n_errors = 0, checks_done = 0, seed = 32'h6D8B0954;
  wire logic      bhe_w  = bhe_oe ? bhe_o : bhe_d;
  wire logic      cbhe_w = cbhe_oe ? cbhe_o : cbhe_d;
  wire alb_data_t pbus   = pb_oe ? pb_o : pm_bus;

  always #10 clk = ~clk;

  alb_top dut (
    .clk, .nrst, .ale, .cpu_addr_low(al), .cpu_addr_high(ah), .addr_bit_zero(bz),
    .addr_bit_twenty(b20), .kbd_gate(kg), .port92_gate(pg), .async_mode(am),
    .bus_clk_quarter(bq), .master_n(mn), .byte_high_en_n_i(bhe_w), .byte_high_en_n_o(bhe_o),
    .byte_high_en_n_oe(bhe_oe), .chan_byte_high_en_n_i(cbhe_w), .chan_byte_high_en_n_o(cbhe_o),
    .chan_byte_high_en_n_oe(cbhe_oe), .chan_addr_latched_lo(lo), .chan_addr_latched_hi(hi),
    .chan_upper_addr(up), .addr_bit_twenty_out(b20_o), .data_hi_sel(sel),
    .io_read_cmd_n(ior), .io_write_cmd_n(iow), .mem_read_cmd_n(mrd), .mem_write_cmd_n(mwr),
    .cpu_data_i(cd), .cpu_data_o(cd_o), .cpu_data_oe(cd_oe), .periph_data_bus_i(pbus),
    .periph_data_bus_o(pb_o), .periph_data_bus_oe(pb_oe));

  alb_periph_model partner (.clk, .rd_n(ior & mrd), .rd_data(pdat), .bus(pm_bus));

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Runs once inputs settle; predicts what the next rising edge stores
  task automatic step;
    logic g;
    g = b20 & kg & pg;
    chk("bhe_oe", !mn, bhe_oe);
    chk("cbhe_oe", mn, cbhe_oe);
    chk("cpu_data_oe", !(ior & mrd), cd_oe);
    chk("periph_oe", !(iow & mwr) & ior & mrd, pb_oe);
    if (!nrst) begin
      e_lo = LATLO_RST; e_hi = LATHI_RST; e_up = UPPER_RST; e_cb = BHE_RST; e_b = BHE_RST;
      e_20 = 0; e_sel = 0; e_cd = DATA_RST; e_pd = DATA_RST;
    end else begin
      if (ale) begin
        e_lo = {al[15:0], bz}; e_hi = al[18:16]; e_cb = bhe_w;
      end
      if (ale | !(am | bq)) e_up = {ah, g, al[18:16]};
      e_20 = g; e_b = cbhe_w; e_sel = !(mn ? bhe_w : cbhe_w); e_cd = pbus; e_pd = cd;
    end
  endtask : step

  task automatic check_all;
    chk("lo", e_lo, lo);
    chk("hi", e_hi, hi);
    chk("upper", e_up, up);
    chk("chan_bhe", e_cb, cbhe_o);
    chk("cpu_bhe", e_b, bhe_o);
    chk("bit20", e_20, b20_o);
    chk("hi_sel", e_sel, sel);
    chk("cpu_data", e_cd, cd_o);
    chk("periph", e_pd, pb_o);
  endtask : check_all

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end

  // Second reset mid-run checks recovery of every latch
  initial begin
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (i > 0) check_all;
      {ale, bz, b20, kg, pg, am, bq, mn, bhe_d, cbhe_d, ior, iow, mrd, mwr} = $random(seed);
      {al, ah} = $random(seed);
      {cd, pdat} = $random(seed);
      nrst = (i > 0 && i != 1500);
      #1 step;
    end
    tally_and_finish;
  end
endmodule : address_latch_buffer_tb

// file: alb_hold.sv
// Transparent-or-hold register slice used for every latched lane group
module alb_hold #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         open,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] q_nxt;

  // Follows while open, freezes the last open value afterwards
  assign q_nxt = open ? d : q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= q_nxt;
    end
  end
endmodule : alb_hold

// file: alb_periph_model.sv
// Far-side peripheral model on the eight-bit data bus
module alb_periph_model
  import alb_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rd_n,
  input  wire alb_pkg::alb_data_t rd_data,
  output      alb_pkg::alb_data_t bus
);
  timeunit 1ns;
  timeprecision 100ps;
  alb_data_t last_r = '0;
  // Released bus flips every cycle so a stale read cannot pass
  assign bus = !rd_n ? rd_data : ~last_r;
  always @(posedge clk) last_r <= bus;
endmodule : alb_periph_model

// file: alb_pkg.sv
// Constants and types for the address latch buffer
package alb_pkg;
  localparam int LOW_W  = 19;
  localparam int HIGH_W = 3;
  localparam int LATLO_W = 17;
  localparam int LATHI_W = 3;
  localparam int UPPER_W = 7;
  localparam int DATA_W  = 8;
  localparam int LOW_TOP = 15;
  localparam int HI_LSB  = 16;
  localparam int HI_MSB  = 18;
  localparam logic [LATLO_W-1:0] LATLO_RST = 17'h00000;
  localparam logic [LATHI_W-1:0] LATHI_RST = 3'h0;
  localparam logic [UPPER_W-1:0] UPPER_RST = 7'h00;
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;
  localparam logic               BHE_RST   = 1'h1;
  localparam logic               FLAG_RST  = 1'h0;

  typedef logic [LOW_W-1:0]   alb_low_t;
  typedef logic [HIGH_W-1:0]  alb_high_t;
  typedef logic [LATLO_W-1:0] alb_latlo_t;
  typedef logic [LATHI_W-1:0] alb_lathi_t;
  typedef logic [UPPER_W-1:0] alb_upper_t;
  typedef logic [DATA_W-1:0]  alb_data_t;

  // Strobe phase, gray along open -> hold -> open
  typedef enum logic [1:0] {
    ALB_OPEN = 2'b00,
    ALB_HOLD = 2'b01
  } alb_phase_e;
endpackage : alb_pkg

// file: alb_top.sv
// Address latch buffer between processor local bus and expansion channel
module alb_top
  import alb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ale,
  input  wire alb_pkg::alb_low_t  cpu_addr_low,
  input  wire alb_pkg::alb_high_t cpu_addr_high,
  input  wire logic              addr_bit_zero,
  input  wire logic              addr_bit_twenty,
  input  wire logic              kbd_gate,
  input  wire logic              port92_gate,
  input  wire logic              async_mode,
  input  wire logic              bus_clk_quarter,
  input  wire logic              master_n,
  input  wire logic              byte_high_en_n_i,
  output      logic              byte_high_en_n_o,
  output      logic              byte_high_en_n_oe,
  input  wire logic              chan_byte_high_en_n_i,
  output      logic              chan_byte_high_en_n_o,
  output      logic              chan_byte_high_en_n_oe,
  output      alb_pkg::alb_latlo_t chan_addr_latched_lo,
  output      alb_pkg::alb_lathi_t chan_addr_latched_hi,
  output      alb_pkg::alb_upper_t chan_upper_addr,
  output      logic              addr_bit_twenty_out,
  output      logic              data_hi_sel,
  input  wire logic              io_read_cmd_n,
  input  wire logic              io_write_cmd_n,
  input  wire logic              mem_read_cmd_n,
  input  wire logic              mem_write_cmd_n,
  input  wire alb_pkg::alb_data_t cpu_data_i,
  output      alb_pkg::alb_data_t cpu_data_o,
  output      logic              cpu_data_oe,
  input  wire alb_pkg::alb_data_t periph_data_bus_i,
  output      alb_pkg::alb_data_t periph_data_bus_o,
  output      logic              periph_data_bus_oe
);
  import alb_pkg::*;

  // Decode
  logic       a20_gated;
  logic       upper_follow;
  logic       upper_open;
  logic       any_read;
  logic       any_write;
  logic       master_on;
  logic       bhe_eff_n;
  alb_latlo_t lo_in;
  alb_lathi_t hi_in;
  alb_upper_t up_in;

  // State
  alb_phase_e phase_r;
  alb_phase_e phase_nxt;
  logic       a20_r;
  logic       hi_sel_r;
  logic       bhe_cpu_r;
  alb_data_t  cpu_data_r;
  alb_data_t  periph_data_r;

  function automatic logic cmd_active(input logic a_n, input logic b_n);
    cmd_active = !a_n || !b_n;
  endfunction : cmd_active

  assign a20_gated    = addr_bit_twenty && kbd_gate && port92_gate;
  assign upper_follow = !async_mode && !bus_clk_quarter;
  assign upper_open   = ale || upper_follow;
  assign lo_in = {cpu_addr_low[LOW_TOP:0], addr_bit_zero};
  assign hi_in = cpu_addr_low[HI_MSB:HI_LSB];
  assign up_in = {cpu_addr_high, a20_gated, cpu_addr_low[HI_MSB:HI_LSB]};
  assign master_on = !master_n;
  // Bus master drives the channel enable; processor side then follows it
  assign bhe_eff_n = master_on ? chan_byte_high_en_n_i : byte_high_en_n_i;
  // Both command pairs share the one data path; reads win a clash
  assign any_read  = cmd_active(io_read_cmd_n, mem_read_cmd_n);
  assign any_write = cmd_active(io_write_cmd_n, mem_write_cmd_n);

  // Latch groups: follow while strobe high, freeze at its fall; upper group also follows while async_mode and bus_clk_quarter are both low
  alb_hold #(.W(LATLO_W), .RST(LATLO_RST)) u_lo (
    .clk  (clk),
    .nrst (nrst),
    .open (ale),
    .d    (lo_in),
    .q    (chan_addr_latched_lo)
  );

  alb_hold #(.W(LATHI_W), .RST(LATHI_RST)) u_hi (
    .clk  (clk),
    .nrst (nrst),
    .open (ale),
    .d    (hi_in),
    .q    (chan_addr_latched_hi)
  );

  alb_hold #(.W(UPPER_W), .RST(UPPER_RST)) u_up (
    .clk  (clk),
    .nrst (nrst),
    .open (upper_open),
    .d    (up_in),
    .q    (chan_upper_addr)
  );

  alb_hold #(.W(1), .RST(BHE_RST)) u_bhe (
    .clk  (clk),
    .nrst (nrst),
    .open (ale),
    .d    (byte_high_en_n_i),
    .q    (chan_byte_high_en_n_o)
  );

  // Phase tracker, only for observing latch cycles
  always_comb begin
    case (phase_r)
      ALB_OPEN: phase_nxt = ale ? ALB_OPEN : ALB_HOLD;
      ALB_HOLD: phase_nxt = ale ? ALB_OPEN : ALB_HOLD;
      default:  phase_nxt = ALB_OPEN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r       <= ALB_OPEN;
      a20_r         <= FLAG_RST;
      hi_sel_r      <= FLAG_RST;
      bhe_cpu_r     <= BHE_RST;
      cpu_data_r    <= DATA_RST;
      periph_data_r <= DATA_RST;
    end else begin
      phase_r       <= phase_nxt;
      a20_r         <= a20_gated;
      hi_sel_r      <= !bhe_eff_n;
      bhe_cpu_r     <= chan_byte_high_en_n_i;
      cpu_data_r    <= periph_data_bus_i;
      periph_data_r <= cpu_data_i;
    end
  end

  assign addr_bit_twenty_out    = a20_r;
  assign data_hi_sel            = hi_sel_r;
  assign chan_byte_high_en_n_oe = !master_on;
  assign byte_high_en_n_o       = bhe_cpu_r;
  assign byte_high_en_n_oe      = master_on;
  assign cpu_data_o             = cpu_data_r;
  assign cpu_data_oe            = any_read;
  assign periph_data_bus_o      = periph_data_r;
  assign periph_data_bus_oe     = any_write && !any_read;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_lo_follow: assert property (ale |=> chan_addr_latched_lo == $past(lo_in))
    else $error("low channel address not transparent");
  a_lo_hold: assert property (!ale |=> $stable(chan_addr_latched_lo))
    else $error("low channel address changed while held");
  a_hi_follow: assert property (ale |=> chan_addr_latched_hi == $past(hi_in))
    else $error("high channel address not transparent");
  a_hi_hold: assert property (!ale ##1 !ale |-> $stable(chan_addr_latched_hi))
    else $error("high channel address changed while held");
  a_up_follow: assert property (upper_follow |=> chan_upper_addr == $past(up_in))
    else $error("upper address not following in half-rate mode");
  a_up_latched: assert property (!ale && !upper_follow |=> $stable(chan_upper_addr))
    else $error("upper address changed while latched");
  a_a20_gate: assert property (!(kbd_gate && port92_gate) |=> !addr_bit_twenty_out)
    else $error("address bit 20 passed while gated off");
  a_bhe_copy: assert property (ale |=> chan_byte_high_en_n_o == $past(byte_high_en_n_i))
    else $error("channel byte-high enable not a copy");
  a_master_dir: assert property (master_on |-> !chan_byte_high_en_n_oe && byte_high_en_n_oe)
    else $error("byte-high enable direction wrong in master mode");
  a_hi_select: assert property (master_n && !byte_high_en_n_i |=> data_hi_sel)
    else $error("upper data half not selected");
  a_data_dir: assert property (any_read |-> cpu_data_oe && !periph_data_bus_oe)
    else $error("peripheral data direction wrong on read");
  a_data_pass: assert property (any_read |=> cpu_data_o == $past(periph_data_bus_i))
    else $error("read data not forwarded");
  // Phase tracker gives a second, independent view of the hold window
  a_phase_hold: assert property (phase_r == ALB_HOLD |-> $stable(chan_addr_latched_lo))
    else $error("low channel address moved in hold phase");
  a_bhe_hold: assert property (!ale |=> $stable(chan_byte_high_en_n_o))
    else $error("channel byte-high enable changed while held");
  a_master_bhe: assert property (master_on |=>
    byte_high_en_n_o == $past(chan_byte_high_en_n_i))
    else $error("processor byte-high enable not formed from channel pin");
  a_a20_pass: assert property (kbd_gate && port92_gate |=>
    addr_bit_twenty_out == $past(addr_bit_twenty))
    else $error("address bit 20 not passed while both gates open");
  a_hi_deselect: assert property (master_n && byte_high_en_n_i |=> !data_hi_sel)
    else $error("upper data half selected while enable inactive");
  a_write_dir: assert property (any_write && !any_read |-> periph_data_bus_oe)
    else $error("peripheral data bus not driven on write");
  a_write_pass: assert property (any_write && !any_read |=>
    periph_data_bus_o == $past(cpu_data_i))
    else $error("write data not forwarded");

  c_latch_cycle: cover property (ale ##1 !ale ##1 !ale ##1 ale);
  c_master_mode: cover property (master_on ##1 master_on);
  c_quarter_latch: cover property (bus_clk_quarter && ale ##1 !ale);
  c_write_pass: cover property (any_write && !any_read ##1 periph_data_bus_oe);
endmodule : alb_top
